// ---- core/adcsq_cfg.svh ----
// Purpose: constants of the converter scan and gain sequencer
// Assumes: 100 MHz clock, byte offsets on a 5-bit I/O address
// Notes: offsets are I/O addresses inside the board's 32-byte window
// Notes on behaviour
// - with interrupt enabled, raise the request once the result FIFO is half full
// - every stored gain code is zero after reset
// - one gain code per channel; offset 04 sets channels 0-3, 05 sets 4-7
// - channels 8 to F reuse the gain code of the channel eight below
// - second contact of each analog jumper pair is sensed and readable
// - channel-mode jumpers choose eight differential or sixteen single-ended inputs
// - outside burst, scans run start to end ascending, every channel between
// - a software start makes one conversion, a trigger makes a full scan
// - software write to offset 0 converts the current channel then advances it, unless burst is set
// - burst converts one fixed channel, a new conversion every 2 us
// - in triggered mode each counter timeout starts one whole scan; the code ignores a timeout that arrives while a scan is running
// - in triggered mode each channel converts oversample times before advancing
// - scan register: end channel high nibble, start low; wraps after end
// - any scan register write resets the current channel to the start
// - 1024-sample result FIFO with empty and half-full flags
// - a full FIFO in burst holds off new conversions until data is read
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH
`define ADCSQ_OFS_DATA 5'h00
`define ADCSQ_OFS_SCAN 5'h02
`define ADCSQ_OFS_BURST 5'h03
`define ADCSQ_OFS_GAIN_LO 5'h04
`define ADCSQ_OFS_GAIN_HI 5'h05
`define ADCSQ_OFS_STATUS 5'h08
`define ADCSQ_OFS_CHAN 5'h0A
`define ADCSQ_OFS_MODE 5'h1A
`define ADCSQ_OFS_TRIG 5'h1B
`define ADCSQ_MODE_TIMED_BIT 0
`define ADCSQ_MODE_OS_LSB 1
`define ADCSQ_MODE_IRQ_BIT 3
`define ADCSQ_RESET_GAIN 2'h0
`define ADCSQ_RESET_SCAN 8'h00
`define ADCSQ_RESET_MODE 4'h0
`define ADCSQ_FIFO_DEPTH 1024
`define ADCSQ_FIFO_AW 10
`define ADCSQ_CLK_NS 10
`define ADCSQ_BURST_NS 2000
`define ADCSQ_BURST_CYC (`ADCSQ_BURST_NS / `ADCSQ_CLK_NS)
`endif

// ---- core/adcsq_pkg.sv ----
// Purpose: shared types of the scan and gain sequencer
// Assumes: nothing beyond the config header
// Notes: states, oversample codes and the result word type only
package adcsq_pkg;
  typedef enum logic [1:0] {ADCSQ_OS1, ADCSQ_OS2, ADCSQ_OS8, ADCSQ_OS16} adcsq_os_t;
  typedef enum {ADCSQ_IDLE, ADCSQ_SETUP, ADCSQ_CONV, ADCSQ_WAIT} adcsq_state_t;
  typedef logic [15:0] adcsq_word_t;
endpackage

// ---- core/adcsq_fifo_if.sv ----
// Purpose: carrier between the sequencer and its result FIFO
// Assumes: both ends on the same clock
// Notes: rdata shows the head word while not empty
`timescale 1ns/10ps
interface adcsq_fifo_if;
  import adcsq_pkg::*;
  logic push;
  logic pop;
  adcsq_word_t wdata;
  adcsq_word_t rdata;
  logic full;
  logic empty;
  logic half;
  modport user (output push, output pop, output wdata, input rdata, input full, input empty,
    input half);
  modport store (input push, input pop, input wdata, output rdata, output full, output empty,
    output half);
endinterface

// ---- core/adcsq_fifo.sv ----
// Purpose: 1024-sample result FIFO with empty, half and full flags
// Assumes: push is ignored when full, pop when empty
// Notes: head word read without latency so a bus read returns it the next cycle
`timescale 1ns/10ps
`include "adcsq_cfg.svh"
module adcsq_fifo (
  input wire logic clk_in,
  input wire logic rstn_in,
  adcsq_fifo_if.store fif
);
  import adcsq_pkg::*;
  adcsq_word_t mem [`ADCSQ_FIFO_DEPTH];
  logic [`ADCSQ_FIFO_AW-1:0] wptr;
  logic [`ADCSQ_FIFO_AW-1:0] rptr;
  logic [`ADCSQ_FIFO_AW:0] count;
  wire do_push = fif.push && !fif.full;
  wire do_pop = fif.pop && !fif.empty;

  // flags decoded from the fill count
  assign fif.rdata = mem[rptr];
  assign fif.empty = (count == 11'h000);
  assign fif.full = (count == 11'h400);
  assign fif.half = (count >= 11'h200);

  // storage has no reset; only pointers matter
  always_ff @(posedge clk_in)
  begin
    if (do_push)
      mem[wptr] <= fif.wdata;
  end

  // pointers wrap naturally at the power-of-two depth
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wptr <= 10'h000;
      rptr <= 10'h000;
      count <= 11'h000;
    end
    else
    begin
      wptr <= wptr + 10'(do_push);
      rptr <= rptr + 10'(do_pop);
      count <= count + 11'(do_push) - 11'(do_pop);
    end
  end

  property p_fifo_count;
    @(posedge clk_in) disable iff (!rstn_in)
    (do_push && !do_pop) |=> (count == $past(count) + 11'h001);
  endproperty
  a_fifo_count: assert property (p_fifo_count) else $error("fifo count did not grow");
endmodule

// ---- core/adcsq_top.sv ----
// Purpose: converter scan, gain and acquisition-mode sequencer
// Assumes: converter raises conv_done_in for one cycle with its result
// Notes: 16-bit register port on a 5-bit address; reads answer next cycle
`timescale 1ns/10ps
`include "adcsq_cfg.svh"
module adcsq_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [15:0] bus_rdata_out,
  input wire logic trig_in,
  input wire logic conv_done_in,
  input wire adcsq_pkg::adcsq_word_t conv_result_in,
  input wire logic narrow_span_select_in,
  input wire logic wide_span_select_in,
  input wire logic unipolar_select_in,
  input wire logic eight_channel_differential_in,
  input wire logic sixteen_channel_single_ended_in,
  output logic conv_start_out,
  output logic [3:0] conv_chan_out,
  output logic [1:0] conv_gain_out,
  output logic fifo_half_flag_out,
  output logic irq_out
);
  import adcsq_pkg::*;
  adcsq_fifo_if fif ();
  adcsq_state_t state;
  logic [1:0] gain [8];
  logic [7:0] scan_lim;
  logic [3:0] mode;
  logic burst_en;
  logic trig_en;
  logic [3:0] cur_chan;
  logic in_scan;
  logic [4:0] os_cnt;
  logic [7:0] per_cnt;

  adcsq_fifo u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .fif(fif)
  );

  // register decode
  wire wr_start = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_DATA);
  wire wr_scan = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_SCAN);
  wire wr_burst = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_BURST);
  wire wr_glo = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_GAIN_LO);
  wire wr_ghi = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_GAIN_HI);
  wire wr_mode = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_MODE);
  wire wr_trig = bus_wr_in && (bus_addr_in == `ADCSQ_OFS_TRIG);
  wire rd_data = bus_rd_in && (bus_addr_in == `ADCSQ_OFS_DATA);

  // scan limits and mode fields
  wire [3:0] start_chan = scan_lim[3:0];
  wire [3:0] end_chan = scan_lim[7:4];
  wire timed_en = mode[`ADCSQ_MODE_TIMED_BIT];
  wire irq_en = mode[`ADCSQ_MODE_IRQ_BIT];
  wire [1:0] os_code = mode[`ADCSQ_MODE_OS_LSB+1:`ADCSQ_MODE_OS_LSB];
  wire differential = eight_channel_differential_in && !sixteen_channel_single_ended_in;

  // oversample count per channel: 1, 2, 8 or 16
  wire [4:0] os_need = (os_code == 2'(ADCSQ_OS1)) ? 5'h01 :
                       (os_code == 2'(ADCSQ_OS2)) ? 5'h02 :
                       (os_code == 2'(ADCSQ_OS8)) ? 5'h08 : 5'h10;
  wire os_last = (os_cnt + 5'h01) == os_need;

  // channel presented to the mux; differential mode folds to eight pairs
  wire [3:0] eff_chan = differential ? {1'b0, cur_chan[2:0]} : cur_chan;
  wire [1:0] cur_gain = gain[cur_chan[2:0]];
  wire [3:0] next_chan = (cur_chan == end_chan) ? start_chan : cur_chan + 4'h1;

  // launch conditions; software start works in every mode
  wire idle = (state == ADCSQ_IDLE);
  wire burst_go = burst_en && timed_en;
  wire trig_go = trig_en && timed_en && !burst_en;
  wire go_sw = idle && wr_start;
  wire go_burst = idle && !wr_start && burst_go && (per_cnt == 8'h00) && !fif.full;
  wire go_trig = idle && !wr_start && !burst_go && trig_go && trig_in;
  wire done = (state == ADCSQ_WAIT) && conv_done_in && !conv_start_out;
  wire scan_more = in_scan && !(os_last && (cur_chan == end_chan));

  // fifo fed straight from the converter, drained by data reads
  assign fif.push = done;
  assign fif.wdata = conv_result_in;
  assign fif.pop = rd_data;

  // per-channel gain codes, two bits each, four to a byte
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_gain
      always_ff @(posedge clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
          gain[gi] <= `ADCSQ_RESET_GAIN;
        else if ((gi < 4) ? wr_glo : wr_ghi)
          gain[gi] <= bus_wdata_in[2*(gi%4)+:2];
      end
    end
  endgenerate

  // software-written control registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scan_lim <= `ADCSQ_RESET_SCAN;
      mode <= `ADCSQ_RESET_MODE;
      burst_en <= 1'b0;
      trig_en <= 1'b0;
    end
    else
    begin
      if (wr_scan)
        scan_lim <= bus_wdata_in[7:0];
      if (wr_mode)
        mode <= bus_wdata_in[3:0];
      if (wr_burst)
        burst_en <= bus_wdata_in[0];
      if (wr_trig)
        trig_en <= bus_wdata_in[0];
    end
  end

  // current channel; a scan write beats any advance in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cur_chan <= 4'h0;
    else if (wr_scan)
      cur_chan <= bus_wdata_in[3:0];
    else if (done && !burst_en && (!in_scan || os_last))
      cur_chan <= next_chan;
  end

  // burst pacing: reload on each launch so starts sit 2 us apart
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      per_cnt <= 8'h00;
    else if (go_burst)
      per_cnt <= 8'(`ADCSQ_BURST_CYC - 1);
    else if (per_cnt != 8'h00)
      per_cnt <= per_cnt - 8'h01;
  end

  // sequencer; triggers during a scan are ignored, not queued
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= ADCSQ_IDLE;
      in_scan <= 1'b0;
      os_cnt <= 5'h00;
    end
    else
    begin
      unique case (state)
        ADCSQ_IDLE:
        begin
          os_cnt <= 5'h00;
          in_scan <= go_trig;
          if (go_sw || go_burst || go_trig)
            state <= ADCSQ_SETUP;
        end
        ADCSQ_SETUP:
          state <= ADCSQ_CONV;
        ADCSQ_CONV:
          state <= ADCSQ_WAIT;
        ADCSQ_WAIT:
        begin
          if (done)
          begin
            os_cnt <= os_last ? 5'h00 : os_cnt + 5'h01;
            state <= scan_more ? ADCSQ_SETUP : ADCSQ_IDLE;
          end
        end
      endcase
    end
  end

  // mux and amplifier set a cycle ahead of the start pulse
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      conv_chan_out <= 4'h0;
      conv_gain_out <= 2'h0;
      conv_start_out <= 1'b0;
    end
    else
    begin
      if (state == ADCSQ_SETUP)
      begin
        conv_chan_out <= eff_chan;
        conv_gain_out <= cur_gain;
      end
      conv_start_out <= (state == ADCSQ_CONV);
    end
  end

  // read mux; status carries the jumper tattletales
  wire [15:0] status_word = {8'h00, sixteen_channel_single_ended_in,
    eight_channel_differential_in, unipolar_select_in, wide_span_select_in,
    narrow_span_select_in, fif.full, fif.half, fif.empty};
  wire [15:0] rd_mux =
    (bus_addr_in == `ADCSQ_OFS_DATA) ? (fif.empty ? 16'h0000 : fif.rdata) :
    (bus_addr_in == `ADCSQ_OFS_SCAN) ? {8'h00, scan_lim} :
    (bus_addr_in == `ADCSQ_OFS_BURST) ? {15'h0000, burst_en} :
    (bus_addr_in == `ADCSQ_OFS_GAIN_LO) ? {8'h00, gain[3], gain[2], gain[1], gain[0]} :
    (bus_addr_in == `ADCSQ_OFS_GAIN_HI) ? {8'h00, gain[7], gain[6], gain[5], gain[4]} :
    (bus_addr_in == `ADCSQ_OFS_STATUS) ? status_word :
    (bus_addr_in == `ADCSQ_OFS_CHAN) ? {12'h000, cur_chan} :
    (bus_addr_in == `ADCSQ_OFS_MODE) ? {12'h000, mode} :
    (bus_addr_in == `ADCSQ_OFS_TRIG) ? {15'h0000, trig_en} : 16'h0000;

  // registered outputs
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bus_rdata_out <= 16'h0000;
      fifo_half_flag_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (bus_rd_in)
        bus_rdata_out <= rd_mux;
      fifo_half_flag_out <= fif.half;
      irq_out <= irq_en && fif.half;
    end
  end

  property p_irq;
    @(posedge clk_in) disable iff (!rstn_in)
    (irq_en && fif.half) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("half full did not raise irq");

  property p_gain_lo;
    @(posedge clk_in) disable iff (!rstn_in)
    wr_glo |=> (gain[1] == $past(bus_wdata_in[3:2]));
  endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain write not stored");

  property p_gain_apply;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == ADCSQ_CONV) |-> (conv_gain_out == gain[cur_chan[2:0]]) ##1 conv_start_out;
  endproperty
  a_gain_apply: assert property (p_gain_apply) else $error("gain not set before start");

  property p_diff_fold;
    @(posedge clk_in) disable iff (!rstn_in)
    (differential && state == ADCSQ_CONV) |-> !conv_chan_out[3];
  endproperty
  a_diff_fold: assert property (p_diff_fold) else $error("differential channel above 7");

  property p_sw_one;
    @(posedge clk_in) disable iff (!rstn_in)
    (go_sw && !burst_en) |=> ##2 conv_start_out ##1 !conv_start_out;
  endproperty
  a_sw_one: assert property (p_sw_one) else $error("software start not one pulse");

  property p_scan_reset;
    @(posedge clk_in) disable iff (!rstn_in)
    wr_scan |=> (cur_chan == $past(bus_wdata_in[3:0]));
  endproperty
  a_scan_reset: assert property (p_scan_reset) else $error("scan write kept channel");

  property p_burst_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    (idle && fif.full && !wr_start && !go_trig) |=> idle;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("started while full");

  property p_burst_pace;
    @(posedge clk_in) disable iff (!rstn_in)
    go_burst |=> (per_cnt == 8'(`ADCSQ_BURST_CYC - 1));
  endproperty
  a_burst_pace: assert property (p_burst_pace) else $error("burst period wrong");

  property p_scan_end;
    @(posedge clk_in) disable iff (!rstn_in)
    (done && in_scan && os_last && cur_chan == end_chan && !wr_scan)
      |=> (idle && cur_chan == start_chan);
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan did not wrap and stop");
endmodule

// ---- testbench/adcsq_conv_model.sv ----
// Purpose: converter stand-in that answers each start pulse
// Assumes: channel and gain are settled at the edge that samples start
// Notes: result low byte echoes gain and channel; junk between answers
`timescale 1ns/10ps
module adcsq_conv_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [3:0] chan_in,
  input wire logic [1:0] gain_in,
  input wire logic [3:0] lat_in,
  output logic done_out,
  output logic [15:0] result_out
);
  logic [4:0] left;
  logic [7:0] echo;
  // zero means idle; inverted junk keeps a stale result from passing
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      left <= 5'h00;
      echo <= 8'h00;
      done_out <= 1'b0;
      result_out <= 16'h0000;
    end
    else
    begin
      done_out <= left == 5'h01;
      result_out <= (left == 5'h01) ? {8'h00, echo} : ~result_out;
      if (start_in)
      begin
        left <= {1'b0, lat_in} + 5'h01;
        echo <= {2'b00, gain_in, chan_in};
      end
      else if (left != 5'h00)
        left <= left - 5'h01;
    end
  end
endmodule

// ---- testbench/adcsq_tb.sv ----
// Purpose: self-checking bench of the scan and gain sequencer
// Assumes: converter model answers every start; bus strobes last one cycle
// Notes: fifo filled by software starts, a burst fill would run too long
`timescale 1ns/10ps
`include "adcsq_cfg.svh"
module adcsq_tb;
  import adcsq_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, trig = 1'b0;
  logic [4:0] addr = 5'h00, jmp = 5'h15;
  logic [15:0] wdata = 16'h0000, rdata, got;
  logic [3:0] lat = 4'h1, chan;
  logic [1:0] gain;
  logic done, start, half, irq;
  adcsq_word_t result;
  int cyc = 0, fail_count = 0, checks_done = 0;
  // 100 MHz clock, cycle count for spacing checks
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // design and converter stand-in; jumper levels come from jmp
  adcsq_top dut_u (.clk_in(clk), .rstn_in(rstn), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .trig_in(trig),
    .conv_done_in(done), .conv_result_in(result), .narrow_span_select_in(jmp[0]),
    .wide_span_select_in(jmp[1]), .unipolar_select_in(jmp[2]),
    .eight_channel_differential_in(jmp[3]), .sixteen_channel_single_ended_in(jmp[4]),
    .conv_start_out(start), .conv_chan_out(chan), .conv_gain_out(gain),
    .fifo_half_flag_out(half), .irq_out(irq));
  adcsq_conv_model conv_u (.clk_in(clk), .rstn_in(rstn), .start_in(start), .chan_in(chan),
    .gain_in(gain), .lat_in(lat), .done_out(done), .result_out(result));
  // compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bus cycles: strobe held one full cycle, read data taken a cycle later
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  // bounded wait for a start or a done pulse
  task automatic wait_for(input bit on_start);
    int n;
    n = 0;
    while ((on_start ? start : done) !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 600), 16'h0001);
    if (n == 600)
      stop_test();
    else
      @(negedge clk);
  endtask
  task automatic sw_conv;
    reg_wr(`ADCSQ_OFS_DATA, 16'h0000);
    wait_for(0);
  endtask
  task automatic pop_chk(input logic [3:0] c, input logic [1:0] g);
    reg_rd(`ADCSQ_OFS_DATA);
    chk({8'h00, got[7:0]}, {10'h000, g, c});
  endtask
  // reset values and jumper sense
  task automatic t_reset;
    reg_rd(`ADCSQ_OFS_GAIN_LO);
    chk(got, 16'h0000);
    reg_rd(`ADCSQ_OFS_GAIN_HI);
    chk(got, 16'h0000);
    reg_rd(`ADCSQ_OFS_STATUS);
    chk(got, {8'h00, jmp, 3'b001});
  endtask
  // gains, a scan from channel 6 to A across channel 8 with wrap, then differential folding
  task automatic t_scan;
    logic [3:0] c;
    reg_wr(`ADCSQ_OFS_GAIN_LO, 16'h00E4);
    reg_wr(`ADCSQ_OFS_GAIN_HI, 16'h001B);
    reg_rd(`ADCSQ_OFS_GAIN_HI);
    chk(got, 16'h001B);
    reg_wr(`ADCSQ_OFS_SCAN, 16'h00A6);
    reg_rd(`ADCSQ_OFS_CHAN);
    chk(got, 16'h0006);
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 5) ? 4'h6 : 4'(6 + i);
      sw_conv();
      pop_chk(c, 2'(16'h1BE4 >> (2 * c[2:0])));
    end
    reg_rd(`ADCSQ_OFS_CHAN);
    chk(got, 16'h0007);
    jmp = 5'h0D;
    lat = 4'h9;
    reg_wr(`ADCSQ_OFS_SCAN, 16'h00F9);
    sw_conv();
    pop_chk(4'h1, 2'h1);
    reg_rd(`ADCSQ_OFS_STATUS);
    chk(got, {8'h00, jmp, 3'b001});
    jmp = 5'h15;
    lat = 4'h1;
  endtask
  // one trigger per oversample code; a channel repeats before moving on
  task automatic t_trig;
    int m;
    reg_wr(`ADCSQ_OFS_SCAN, 16'h0032);
    reg_wr(`ADCSQ_OFS_TRIG, 16'h0001);
    for (int k = 0; k < 4; k++)
    begin
      m = 1 << (k + int'(k > 1));
      reg_wr(`ADCSQ_OFS_MODE, 16'(2 * k + 1));
      @(negedge clk);
      trig = 1'b1;
      @(negedge clk);
      trig = 1'b0;
      repeat (2 * m) wait_for(0);
      repeat (20) @(negedge clk);
      for (int i = 0; i < 2 * m; i++)
        pop_chk(4'(2 + i / m), 2'(2 + i / m));
      reg_rd(`ADCSQ_OFS_STATUS);
      chk({15'h0000, got[0]}, 16'h0001);
    end
    reg_wr(`ADCSQ_OFS_MODE, 16'h0000);
  endtask
  // fill to full, half flag and request, burst hold-off and spacing, drain
  task automatic t_fill;
    int n;
    int t1;
    reg_wr(`ADCSQ_OFS_SCAN, 16'h0000);
    reg_wr(`ADCSQ_OFS_MODE, 16'h0008);
    for (int i = 0; i < 1024; i++)
    begin
      sw_conv();
      if (i == 510 || i == 511)
      begin
        repeat (2) @(negedge clk);
        chk(16'(half), 16'(i - 510));
        chk(16'(irq), 16'(i - 510));
      end
    end
    reg_rd(`ADCSQ_OFS_STATUS);
    chk({13'h0000, got[2:0]}, 16'h0006);
    reg_wr(`ADCSQ_OFS_MODE, 16'h0000);
    @(negedge clk);
    chk(16'(irq), 16'h0000);
    reg_wr(`ADCSQ_OFS_BURST, 16'h0001);
    reg_wr(`ADCSQ_OFS_MODE, 16'h0001);
    n = 0;
    repeat (450)
    begin
      @(negedge clk);
      n += int'(start === 1'b1);
    end
    chk(16'(n), 16'h0000);
    // four pops leave room for four results; the first start is missed while popping
    repeat (4) reg_rd(`ADCSQ_OFS_DATA);
    wait_for(1);
    t1 = cyc;
    wait_for(1);
    chk(16'(cyc - t1), 16'(`ADCSQ_BURST_CYC));
    wait_for(0);
    reg_wr(`ADCSQ_OFS_BURST, 16'h0000);
    for (int i = 0; i < 1024; i++)
      reg_rd(`ADCSQ_OFS_DATA);
    reg_rd(`ADCSQ_OFS_STATUS);
    chk({13'h0000, got[2:0]}, 16'h0001);
  endtask
  // reset for three cycles, then each scenario in turn
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_scan();
    t_trig();
    t_fill();
    stop_test();
  end
endmodule
